// [src/fwr_pkg.sv]
// constants, types and register map of the fault waveform recorder
package fwr_pkg;
  // clock and sampling time base
  localparam int CLK_PERIOD_NS = 100;
  localparam int SAMPLE_PERIOD_NS = 1000000;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_MS = 1;

  // storage geometry
  localparam int LEN_W = 13;
  localparam int TOT_W = 14;
  localparam int PRE_AW = 9;
  localparam int STORE_AW = 14;
  localparam int REC_NUM = 8;
  localparam int REC_IW = 3;
  localparam int NUM_CH = 14;
  localparam int CH_W = 16;
  localparam int MARK_W = 4;

  typedef logic [LEN_W-1:0] fwr_len_t;

  // limits and settings in ms, then in samples
  localparam int REC_LIMIT_MS = 5000;
  localparam int STORE_LIMIT_MS = 15000;
  localparam int PRE_MIN_MS = 50;
  localparam int PRE_MAX_MS = 500;
  localparam int PRE_DEF_MS = 250;
  localparam int POST_MIN_MS = 50;
  localparam int POST_MAX_MS = 500;
  localparam int POST_DEF_MS = 100;
  localparam int MAXLEN_MIN_MS = 300;
  localparam int MAXLEN_MAX_MS = 5000;
  localparam int MAXLEN_DEF_MS = 2000;
  localparam int CAPT_MIN_MS = 100;
  localparam int CAPT_MAX_MS = 5000;
  localparam int CAPT_DEF_MS = 500;

  localparam int REC_LIMIT_SAMP = REC_LIMIT_MS / SAMPLE_MS;
  localparam int STORE_LIMIT_SAMP = STORE_LIMIT_MS / SAMPLE_MS;
  localparam fwr_len_t PRE_DEF_SAMP = fwr_len_t'(PRE_DEF_MS / SAMPLE_MS);
  localparam fwr_len_t POST_DEF_SAMP = fwr_len_t'(POST_DEF_MS / SAMPLE_MS);
  localparam fwr_len_t MAXLEN_DEF_SAMP = fwr_len_t'(MAXLEN_DEF_MS / SAMPLE_MS);
  localparam fwr_len_t CAPT_DEF_SAMP = fwr_len_t'(CAPT_DEF_MS / SAMPLE_MS);

  // channel order: ia ib ic i0 ua ub uc uaux idA idB idC irA irB irC
  typedef logic [NUM_CH-1:0][CH_W-1:0] fwr_meas_t;

  // event mark bits
  localparam int MARK_PICKUP = 0;
  localparam int MARK_TRIP = 1;
  localparam int MARK_BININ = 2;
  localparam int MARK_ACTIVE = 3;

  typedef struct packed {
    logic [MARK_W-1:0] marks;
    fwr_meas_t ch;
  } fwr_sample_s;

  typedef struct packed {
    logic pickup;
    logic trip;
    logic binIn;
    logic reclose;
  } fwr_prot_s;

  typedef struct packed {
    logic [STORE_AW-1:0] start;
    fwr_len_t len;
    logic [PRE_AW-1:0] pre;
    logic [31:0] stamp;
    logic tripped;
  } fwr_rec_s;

  typedef enum logic [1:0] {
    TRIG_SAVE_PICKUP = 2'h0,
    TRIG_SAVE_TRIP = 2'h1,
    TRIG_START_TRIP = 2'h2
  } fwr_trig_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_HOLD = 2'h1,
    ST_POST = 2'h2,
    ST_DRAIN = 2'h3
  } fwr_state_e;

  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PRE = 8'h04;
  localparam logic [7:0] REG_POST = 8'h08;
  localparam logic [7:0] REG_MAXLEN = 8'h0c;
  localparam logic [7:0] REG_CAPT = 8'h10;
  localparam logic [7:0] REG_CMD = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_RECSEL = 8'h1c;
  localparam logic [7:0] REG_SAMPSEL = 8'h20;
  localparam logic [7:0] REG_RECINFO = 8'h24;
  localparam logic [7:0] REG_RECTIME = 8'h28;
  localparam logic [7:0] REG_SAMPDATA = 8'h2c;
  localparam logic [7:0] REG_TIME = 8'h30;

  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SCOPE_BIT = 2;
  localparam int CTRL_XFER_BIT = 3;
  localparam int CTRL_XTRIP_BIT = 4;
  localparam int CTRL_INF_BIT = 5;
  localparam int CMD_TRIG_BIT = 0;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_COUNT_LSB = 4;
  localparam int STAT_TOTAL_LSB = 16;
  localparam int SEL_CHAN_LSB = 16;
  localparam int INFO_PRE_LSB = 16;
  localparam int INFO_TRIP_BIT = 28;
endpackage : fwr_pkg

// [src/fwr_recorder.sv]
// fault waveform recorder: pre-trigger ring, record store, trigger control, register port
`timescale 1ns/100ps
//
// How it works
// [R01] sample all channels every 1 ms into ring
// [R02] fourteen channels: currents, voltages, aux, diff, restraint
// [R03] no record longer than five seconds
// [R04] eight records and fifteen seconds at most
// [R05] new fault always accepted, no acknowledge
// [R06] drop oldest records until new one fits
// [R07] start by pickup, binary input or command
// [R08] samples stamped on shared synchronised time base
// [R09] event marks stored beside analog samples
// [R10] transfer request after pickup or only trip
// [R11] pickup is reference; keep on pickup or trip
// [R12] trip mode: trip is reference and criterion
// [R13] record holds pre samples and post samples
// [R14] scope: single fault or whole reclose disturbance
// [R15] pre time 0.05-0.50 s, default 0.25
// [R16] post time 0.05-0.50 s, default 0.10
// [R17] max length 0.30-5.00 s, default 2.00
// [R18] manual capture edge started, own length
// [R19] infinite capture follows binary input level
// [R20] recording active shown while capture runs
module fwr_recorder #(
  parameter int SAMPLE_CYCLES = fwr_pkg::SAMPLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire fwr_pkg::fwr_meas_t measIn,
  input wire fwr_pkg::fwr_prot_s prot,
  input wire logic syncLoad,
  input wire logic [31:0] syncTime,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  output logic recordActive,
  output logic recordStartEvent,
  output logic xferRequest
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  fwr_pkg::fwr_sample_s preMem [2**fwr_pkg::PRE_AW];
  fwr_pkg::fwr_sample_s storeMem [2**fwr_pkg::STORE_AW];
  fwr_pkg::fwr_rec_s recTab_r [fwr_pkg::REC_NUM];

  logic [31:0] tickCnt_r;
  logic tick_r;
  logic [31:0] timeBase_r;
  logic pickPrev_r;
  logic tripPrev_r;
  logic binPrev_r;
  logic cmdPend_r;

  fwr_pkg::fwr_trig_e trigMode_r;
  logic scopeDist_r;
  logic xferEn_r;
  logic xferTripOnly_r;
  logic captInf_r;
  fwr_pkg::fwr_len_t preSet_r;
  fwr_pkg::fwr_len_t postSet_r;
  fwr_pkg::fwr_len_t maxSet_r;
  fwr_pkg::fwr_len_t captSet_r;

  fwr_pkg::fwr_state_e state_r;
  logic manual_r;
  logic manualBin_r;
  logic tripSeen_r;
  fwr_pkg::fwr_len_t budget_r;
  fwr_pkg::fwr_len_t bodyCnt_r;
  fwr_pkg::fwr_len_t postCnt_r;
  fwr_pkg::fwr_len_t recLen_r;
  logic [fwr_pkg::PRE_AW-1:0] recPre_r;
  logic [31:0] recStamp_r;
  logic [fwr_pkg::STORE_AW-1:0] recStart_r;
  logic [fwr_pkg::PRE_AW-1:0] preWr_r;
  logic [fwr_pkg::PRE_AW-1:0] copyPtr_r;
  logic [fwr_pkg::PRE_AW-1:0] endPtr_r;
  logic [fwr_pkg::STORE_AW-1:0] storeWr_r;

  logic [fwr_pkg::REC_IW-1:0] head_r;
  logic [fwr_pkg::REC_IW:0] count_r;
  logic [fwr_pkg::TOT_W-1:0] total_r;

  logic [fwr_pkg::REC_IW-1:0] recSel_r;
  fwr_pkg::fwr_len_t sampIdx_r;
  logic [3:0] chanSel_r;

  logic crit;
  logic refEdge;
  logic manEdge;
  logic startNow;
  logic [fwr_pkg::PRE_AW-1:0] effPre;
  logic copyGo;
  logic overLimit;
  logic copyEn;
  logic dropOld;
  logic done;
  logic keep;
  logic commit;
  logic [fwr_pkg::REC_IW-1:0] tail;
  logic [fwr_pkg::REC_IW-1:0] recIdx;
  fwr_pkg::fwr_sample_s rdSample;
  logic [31:0] rdMux;

  function automatic fwr_pkg::fwr_len_t clampLen(input logic [31:0] v, input int lo, input int hi);
    clampLen = (v < 32'(lo)) ? fwr_pkg::fwr_len_t'(lo) :
               (v > 32'(hi)) ? fwr_pkg::fwr_len_t'(hi) : v[fwr_pkg::LEN_W-1:0];
  endfunction : clampLen

  ////////////////////////////////////////////////////////////////////////////
  // sample tick and shared time base

  // a sync load restarts the divider so every line end samples on the same edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tickCnt_r <= 32'h0;
      tick_r <= 1'b0;
      timeBase_r <= 32'h0;
    end
    else if (syncLoad)
    begin
      tickCnt_r <= 32'h0;
      tick_r <= 1'b0;
      timeBase_r <= syncTime; // see [R08]
    end
    else
    begin
      tick_r <= (tickCnt_r == 32'(SAMPLE_CYCLES - 1)); // see [R01]
      tickCnt_r <= (tickCnt_r == 32'(SAMPLE_CYCLES - 1)) ? 32'h0 : tickCnt_r + 32'h1;
      if (tick_r)
        timeBase_r <= timeBase_r + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger detection

  always_comb
  begin
    if (trigMode_r == fwr_pkg::TRIG_START_TRIP)
      crit = prot.trip; // see [R12]
    else
      crit = prot.pickup; // see [R11]
    if (scopeDist_r)
      crit = crit | prot.reclose; // see [R14]
  end

  assign refEdge = tick_r && ((trigMode_r == fwr_pkg::TRIG_START_TRIP) ? (prot.trip & ~tripPrev_r)
                                                                       : (prot.pickup & ~pickPrev_r)); // see [R07]
  assign manEdge = tick_r && ((prot.binIn & ~binPrev_r) | cmdPend_r); // see [R18]
  assign startNow = (state_r == fwr_pkg::ST_IDLE) && (refEdge || manEdge); // see [R05]
  // pre time never eats the whole length budget
  assign effPre = (preSet_r < maxSet_r) ? preSet_r[fwr_pkg::PRE_AW-1:0]
                                        : fwr_pkg::PRE_AW'(maxSet_r - fwr_pkg::fwr_len_t'(1));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pickPrev_r <= 1'b0;
      tripPrev_r <= 1'b0;
      binPrev_r <= 1'b0;
    end
    else if (tick_r)
    begin
      pickPrev_r <= prot.pickup;
      tripPrev_r <= prot.trip;
      binPrev_r <= prot.binIn;
    end
  end

  // command held until the next tick; a new write wins over the consume
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cmdPend_r <= 1'b0;
    else if (regWr && regAddr == fwr_pkg::REG_CMD && regWrData[fwr_pkg::CMD_TRIG_BIT])
      cmdPend_r <= 1'b1; // see [R07]
    else if (tick_r)
      cmdPend_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pre-trigger ring, always running

  always_ff @(posedge clk)
  begin
    if (tick_r)
      preMem[preWr_r] <= {(state_r != fwr_pkg::ST_IDLE) | startNow, prot.binIn, prot.trip, prot.pickup,
                          measIn}; // see [R02] see [R09]
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      preWr_r <= '0;
    else if (tick_r)
      preWr_r <= preWr_r + fwr_pkg::PRE_AW'(1); // see [R01]
  end

  ////////////////////////////////////////////////////////////////////////////
  // copy into the record store

  assign copyGo = (state_r != fwr_pkg::ST_IDLE) && (copyPtr_r != endPtr_r);
  assign overLimit = (int'(total_r) + int'(recLen_r) + 1) > fwr_pkg::STORE_LIMIT_SAMP;
  assign copyEn = copyGo && !overLimit;
  // space is made one record per cycle, copying stalls meanwhile
  assign dropOld = (count_r != '0) &&
                   ((copyGo && overLimit) || (startNow && count_r == (fwr_pkg::REC_IW + 1)'(fwr_pkg::REC_NUM)));
  assign done = (state_r == fwr_pkg::ST_DRAIN) && !copyGo;
  assign keep = manual_r || trigMode_r != fwr_pkg::TRIG_SAVE_TRIP || tripSeen_r; // see [R11]
  assign commit = done && keep;
  assign tail = head_r + count_r[fwr_pkg::REC_IW-1:0];

  always_ff @(posedge clk)
  begin
    if (copyEn)
      storeMem[storeWr_r] <= preMem[copyPtr_r];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      storeWr_r <= '0;
    else if (done && !keep)
      storeWr_r <= recStart_r; // see [R11]
    else if (copyEn)
      storeWr_r <= storeWr_r + fwr_pkg::STORE_AW'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // record table

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      head_r <= '0;
      count_r <= '0;
      total_r <= '0;
      for (int i = 0; i < fwr_pkg::REC_NUM; i++)
        recTab_r[i] <= '0;
    end
    else if (dropOld)
    begin
      head_r <= head_r + fwr_pkg::REC_IW'(1); // see [R06] see [R04]
      count_r <= count_r - (fwr_pkg::REC_IW + 1)'(1);
      total_r <= total_r - fwr_pkg::TOT_W'(recTab_r[head_r].len);
    end
    else if (commit)
    begin
      recTab_r[tail] <= '{start: recStart_r, len: recLen_r, pre: recPre_r, stamp: recStamp_r,
                          tripped: tripSeen_r}; // see [R05]
      count_r <= count_r + (fwr_pkg::REC_IW + 1)'(1);
      total_r <= total_r + fwr_pkg::TOT_W'(recLen_r); // see [R04]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture sequence

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= fwr_pkg::ST_IDLE;
      manual_r <= 1'b0;
      manualBin_r <= 1'b0;
      tripSeen_r <= 1'b0;
      budget_r <= '0;
      bodyCnt_r <= '0;
      postCnt_r <= '0;
      recLen_r <= '0;
      recPre_r <= '0;
      recStamp_r <= 32'h0;
      recStart_r <= '0;
      copyPtr_r <= '0;
      endPtr_r <= '0;
    end
    else
    begin
      if (copyEn)
      begin
        copyPtr_r <= copyPtr_r + fwr_pkg::PRE_AW'(1);
        recLen_r <= recLen_r + fwr_pkg::fwr_len_t'(1);
      end
      if (state_r != fwr_pkg::ST_IDLE && prot.trip)
        tripSeen_r <= 1'b1;
      unique case (state_r)
        fwr_pkg::ST_IDLE:
          if (startNow)
          begin
            state_r <= fwr_pkg::ST_HOLD;
            manual_r <= !refEdge; // protection wins when both arrive
            manualBin_r <= !refEdge && prot.binIn && !binPrev_r;
            tripSeen_r <= prot.trip;
            copyPtr_r <= preWr_r - effPre; // see [R13] see [R15]
            endPtr_r <= preWr_r + fwr_pkg::PRE_AW'(1);
            recPre_r <= effPre;
            recStamp_r <= timeBase_r; // see [R08]
            recStart_r <= storeWr_r;
            recLen_r <= '0;
            budget_r <= maxSet_r - fwr_pkg::fwr_len_t'(effPre) - fwr_pkg::fwr_len_t'(1); // see [R17] see [R03]
            bodyCnt_r <= (captSet_r < maxSet_r ? captSet_r : maxSet_r) - fwr_pkg::fwr_len_t'(1); // see [R18]
          end
        fwr_pkg::ST_HOLD:
          if (tick_r)
          begin
            if (budget_r == '0)
              state_r <= fwr_pkg::ST_DRAIN; // see [R17]
            else
            begin
              budget_r <= budget_r - fwr_pkg::fwr_len_t'(1);
              endPtr_r <= preWr_r + fwr_pkg::PRE_AW'(1);
              if (!manual_r && !crit)
              begin
                state_r <= fwr_pkg::ST_POST; // see [R16]
                postCnt_r <= postSet_r - fwr_pkg::fwr_len_t'(1);
              end
              else if (manual_r && captInf_r && manualBin_r)
              begin
                if (!prot.binIn)
                begin
                  state_r <= fwr_pkg::ST_POST; // see [R19]
                  postCnt_r <= postSet_r - fwr_pkg::fwr_len_t'(1);
                end
              end
              else if (manual_r && !captInf_r)
              begin
                if (bodyCnt_r == '0)
                begin
                  state_r <= fwr_pkg::ST_POST; // see [R18]
                  postCnt_r <= postSet_r - fwr_pkg::fwr_len_t'(1);
                end
                else
                  bodyCnt_r <= bodyCnt_r - fwr_pkg::fwr_len_t'(1);
              end
            end
          end
        fwr_pkg::ST_POST:
          if (tick_r)
          begin
            if (budget_r == '0 || postCnt_r == '0)
              state_r <= fwr_pkg::ST_DRAIN; // see [R13]
            else
            begin
              budget_r <= budget_r - fwr_pkg::fwr_len_t'(1);
              endPtr_r <= preWr_r + fwr_pkg::PRE_AW'(1);
              postCnt_r <= postCnt_r - fwr_pkg::fwr_len_t'(1);
              if (!manual_r && scopeDist_r && crit)
                state_r <= fwr_pkg::ST_HOLD; // see [R14]
            end
          end
        fwr_pkg::ST_DRAIN:
          if (done)
            state_r <= fwr_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indications

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      recordActive <= 1'b0;
      recordStartEvent <= 1'b0;
      xferRequest <= 1'b0;
    end
    else
    begin
      recordActive <= (state_r != fwr_pkg::ST_IDLE) || startNow; // see [R20]
      recordStartEvent <= startNow;
      xferRequest <= commit && !manual_r && xferEn_r && (!xferTripOnly_r || tripSeen_r); // see [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trigMode_r <= fwr_pkg::TRIG_SAVE_PICKUP;
      scopeDist_r <= 1'b0;
      xferEn_r <= 1'b0;
      xferTripOnly_r <= 1'b0;
      captInf_r <= 1'b0;
      preSet_r <= fwr_pkg::PRE_DEF_SAMP;
      postSet_r <= fwr_pkg::POST_DEF_SAMP;
      maxSet_r <= fwr_pkg::MAXLEN_DEF_SAMP;
      captSet_r <= fwr_pkg::CAPT_DEF_SAMP;
      recSel_r <= '0;
      sampIdx_r <= '0;
      chanSel_r <= 4'h0;
    end
    else if (regWr)
    begin
      unique case (regAddr)
        fwr_pkg::REG_CTRL:
        begin
          // the unused mode code falls back to the default
          trigMode_r <= (regWrData[fwr_pkg::CTRL_MODE_LSB +: 2] == 2'h3) ? fwr_pkg::TRIG_SAVE_PICKUP
                        : fwr_pkg::fwr_trig_e'(regWrData[fwr_pkg::CTRL_MODE_LSB +: 2]);
          scopeDist_r <= regWrData[fwr_pkg::CTRL_SCOPE_BIT];
          xferEn_r <= regWrData[fwr_pkg::CTRL_XFER_BIT];
          xferTripOnly_r <= regWrData[fwr_pkg::CTRL_XTRIP_BIT];
          captInf_r <= regWrData[fwr_pkg::CTRL_INF_BIT];
        end
        fwr_pkg::REG_PRE: preSet_r <= clampLen(regWrData, fwr_pkg::PRE_MIN_MS / fwr_pkg::SAMPLE_MS,
                                                fwr_pkg::PRE_MAX_MS / fwr_pkg::SAMPLE_MS); // see [R15]
        fwr_pkg::REG_POST: postSet_r <= clampLen(regWrData, fwr_pkg::POST_MIN_MS / fwr_pkg::SAMPLE_MS,
                                                  fwr_pkg::POST_MAX_MS / fwr_pkg::SAMPLE_MS); // see [R16]
        fwr_pkg::REG_MAXLEN: maxSet_r <= clampLen(regWrData, fwr_pkg::MAXLEN_MIN_MS / fwr_pkg::SAMPLE_MS,
                                                   fwr_pkg::REC_LIMIT_SAMP); // see [R17] see [R03]
        fwr_pkg::REG_CAPT: captSet_r <= clampLen(regWrData, fwr_pkg::CAPT_MIN_MS / fwr_pkg::SAMPLE_MS,
                                                  fwr_pkg::CAPT_MAX_MS / fwr_pkg::SAMPLE_MS); // see [R18]
        fwr_pkg::REG_RECSEL: recSel_r <= regWrData[fwr_pkg::REC_IW-1:0];
        fwr_pkg::REG_SAMPSEL:
        begin
          sampIdx_r <= regWrData[fwr_pkg::LEN_W-1:0];
          chanSel_r <= regWrData[fwr_pkg::SEL_CHAN_LSB +: 4];
        end
        default: ;
      endcase
    end
  end

  assign recIdx = head_r + recSel_r;
  assign rdSample = storeMem[recTab_r[recIdx].start + fwr_pkg::STORE_AW'(sampIdx_r)];

  always_comb
  begin
    rdMux = 32'h0;
    unique case (regAddr)
      fwr_pkg::REG_CTRL: rdMux = 32'({captInf_r, xferTripOnly_r, xferEn_r, scopeDist_r, trigMode_r});
      fwr_pkg::REG_PRE: rdMux = 32'(preSet_r);
      fwr_pkg::REG_POST: rdMux = 32'(postSet_r);
      fwr_pkg::REG_MAXLEN: rdMux = 32'(maxSet_r);
      fwr_pkg::REG_CAPT: rdMux = 32'(captSet_r);
      fwr_pkg::REG_STATUS:
      begin
        rdMux[fwr_pkg::STAT_ACTIVE_BIT] = recordActive;
        rdMux[fwr_pkg::STAT_COUNT_LSB +: fwr_pkg::REC_IW + 1] = count_r;
        rdMux[fwr_pkg::STAT_TOTAL_LSB +: fwr_pkg::TOT_W] = total_r;
      end
      fwr_pkg::REG_RECSEL: rdMux = 32'(recSel_r);
      fwr_pkg::REG_SAMPSEL: rdMux = {12'h0, chanSel_r, 3'h0, sampIdx_r};
      fwr_pkg::REG_RECINFO:
        if (32'(recSel_r) < 32'(count_r))
        begin
          rdMux[fwr_pkg::LEN_W-1:0] = recTab_r[recIdx].len;
          rdMux[fwr_pkg::INFO_PRE_LSB +: fwr_pkg::PRE_AW] = recTab_r[recIdx].pre;
          rdMux[fwr_pkg::INFO_TRIP_BIT] = recTab_r[recIdx].tripped;
        end
      fwr_pkg::REG_RECTIME: rdMux = recTab_r[recIdx].stamp;
      fwr_pkg::REG_SAMPDATA:
        if (32'(chanSel_r) < 32'(fwr_pkg::NUM_CH))
          rdMux = 32'(rdSample.ch[chanSel_r]);
        else
          rdMux = 32'(rdSample.marks);
      fwr_pkg::REG_TIME: rdMux = timeBase_r;
      default: rdMux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      regRdData <= 32'h0;
    else
      regRdData <= regRd ? rdMux : 32'h0;
  end

endmodule : fwr_recorder

// [tb/fwr_recorder_props.sv]
// port assertions of the fault waveform recorder
`timescale 1ns/100ps
module fwr_recorder_props #(
  parameter int SAMPLE_CYCLES = fwr_pkg::SAMPLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  input wire logic recordActive,
  input wire logic recordStartEvent,
  input wire logic xferRequest
);
  // post time alone spans at least this many clocks
  localparam int MIN_C = fwr_pkg::POST_MIN_MS * SAMPLE_CYCLES;
  // slack of one clock per sample covers the store copy
  localparam int MAX_C = (fwr_pkg::REC_LIMIT_SAMP + 1) * (SAMPLE_CYCLES + 1);
  int actCnt_r;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      actCnt_r <= 0;
    else
      actCnt_r <= recordActive ? actCnt_r + 1 : 0;
  end
  sequence s_start;
    recordStartEvent && recordActive;
  endsequence
  sequence s_commit;
    xferRequest ##[0:1] !recordActive;
  endsequence
  ////////////////////////////////////////////////////////////
  chk_start_active: assert property (recordStartEvent |-> s_start)
    else $error("start without active");
  chk_start_once: assert property (recordStartEvent |=> !recordStartEvent [*2])
    else $error("start pulse too long");
  chk_no_retrigger: assert property (recordStartEvent |-> !$past(recordActive))
    else $error("start while recording");
  chk_rise_cause: assert property ($rose(recordActive) |-> recordStartEvent)
    else $error("active rose without start");
  chk_xfer_pulse: assert property (xferRequest |=> !xferRequest)
    else $error("transfer pulse too long");
  chk_xfer_commit: assert property (xferRequest |-> s_commit)
    else $error("transfer not at record end");
  chk_rd_quiet: assert property (!$past(regRd) |-> regRdData == 32'h0)
    else $error("read data outside read slot");
  chk_min_span: assert property ($fell(recordActive) |-> actCnt_r >= MIN_C)
    else $error("record ended too early");
  chk_max_span: assert property (recordActive |-> actCnt_r <= MAX_C)
    else $error("record ran too long");
endmodule : fwr_recorder_props

// [tb/fwr_prot_model.sv]
// protection logic and measurement front end model
`timescale 1ns/100ps
module fwr_prot_model (
  input wire logic clk,
  output fwr_pkg::fwr_meas_t measIn,
  output fwr_pkg::fwr_prot_s prot
);
  logic [7:0] step = 8'h00;
  initial prot = '0;
  // low byte moves every clock, stale data cannot match
  always @(posedge clk)
    step <= step + 8'h01;
  always_comb
    for (int k = 0; k < fwr_pkg::NUM_CH; k++)
      measIn[k] = {8'(k + 8'ha0), step};
  task automatic drive(input logic [3:0] v, input int cyc);
    @(posedge clk);
    prot <= v;
    repeat (cyc) @(posedge clk);
    prot <= '0;
  endtask : drive
endmodule : fwr_prot_model

// [tb/fwr_recorder_tb.sv]
// self-checking bench of the fault waveform recorder
`timescale 1ns/100ps
module fwr_recorder_tb;
  localparam int SC = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  fwr_pkg::fwr_meas_t measIn;
  fwr_pkg::fwr_prot_s prot;
  logic syncLoad = 1'b0;
  logic [31:0] syncTime = 32'h0;
  logic [7:0] regAddr = 8'h0;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  logic recordActive;
  logic recordStartEvent;
  logic xferRequest;
  logic [31:0] d;
  int errTotal = 0;
  int nTests = 0;
  int nXfer = 0;
  logic [31:0] ctl [4] = '{32'h08, 32'h09, 32'h0a, 32'h18};
  logic [3:0] stim [4] = '{4'h8, 4'h8, 4'hc, 4'h8};
  int expCnt [4] = '{1, 1, 2, 3};
  int expX [4] = '{1, 1, 2, 2};
  always #50 clk = ~clk;
  fwr_recorder #(.SAMPLE_CYCLES(SC)) fwr_recorder_inst (.clk(clk), .rst(rst), .measIn(measIn), .prot(prot),
    .syncLoad(syncLoad), .syncTime(syncTime), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .recordActive(recordActive), .recordStartEvent(recordStartEvent),
    .xferRequest(xferRequest));
  fwr_prot_model fwr_prot_model_inst (.clk(clk), .measIn(measIn), .prot(prot));
  always @(posedge clk)
    if (xferRequest === 1'b1)
      nXfer++;
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("Error: %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    d = regRdData;
  endtask : rd
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(n, d, e);
  endtask : rc
  task automatic waitRec;
    repeat (3 * SC) if (recordActive !== 1'b1) @(posedge clk);
    repeat (800 * SC) if (recordActive !== 1'b0) @(posedge clk);
    chk("idle", {31'h0, recordActive}, 32'h0);
  endtask : waitRec
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (90000) @(posedge clk);
    errTotal++;
    give_verdict();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc("pre", fwr_pkg::REG_PRE, 32'hfa);
    rc("post", fwr_pkg::REG_POST, 32'h64);
    rc("maxlen", fwr_pkg::REG_MAXLEN, 32'h7d0);
    rc("capt", fwr_pkg::REG_CAPT, 32'h1f4);
    rc("hole", 8'hfc, 32'h0);
    wr(fwr_pkg::REG_PRE, 32'h1);
    wr(fwr_pkg::REG_POST, 32'h3e7);
    wr(fwr_pkg::REG_MAXLEN, 32'h1);
    wr(fwr_pkg::REG_CAPT, 32'h1);
    rc("preLo", fwr_pkg::REG_PRE, 32'h32);
    rc("postHi", fwr_pkg::REG_POST, 32'h1f4);
    rc("maxLo", fwr_pkg::REG_MAXLEN, 32'h12c);
    rc("captLo", fwr_pkg::REG_CAPT, 32'h64);
    wr(fwr_pkg::REG_POST, 32'h0);
    @(posedge clk);
    syncTime <= 32'h0001_2345;
    syncLoad <= 1'b1;
    @(posedge clk);
    syncLoad <= 1'b0;
    rc("time", fwr_pkg::REG_TIME, 32'h0001_2345);
    $display("test settings done");
    // fill the ring past the pre time
    repeat (60 * SC) @(posedge clk);
    for (int i = 0; i < 4; i++)
    begin
      wr(fwr_pkg::REG_CTRL, ctl[i]);
      fwr_prot_model_inst.drive(stim[i], 10 * SC);
      waitRec();
      rd(fwr_pkg::REG_STATUS);
      chk("count", {28'h0, d[7:4]}, expCnt[i]);
      chk("xfer", nXfer, expX[i]);
    end
    wr(fwr_pkg::REG_RECSEL, 32'h1);
    rd(fwr_pkg::REG_RECINFO);
    chk("trip", {31'h0, d[28]}, 32'h1);
    chk("preN", {23'h0, d[24:16]}, 32'h32);
    wr(fwr_pkg::REG_SAMPSEL, 32'h000e_0032);
    rd(fwr_pkg::REG_SAMPDATA);
    chk("mark", {31'h0, d[1]}, 32'h1);
    $display("test protection done");
    wr(fwr_pkg::REG_CTRL, 32'h0);
    fwr_prot_model_inst.drive(4'h2, 2 * SC);
    waitRec();
    wr(fwr_pkg::REG_RECSEL, 32'h3);
    rc("manLen", fwr_pkg::REG_RECINFO, 32'h0032_00c8);
    for (int k = 0; k < fwr_pkg::NUM_CH; k++)
    begin
      wr(fwr_pkg::REG_SAMPSEL, {12'h0, 4'(k), 16'h000a});
      rd(fwr_pkg::REG_SAMPDATA);
      chk("chan", {24'h0, d[15:8]}, 32'ha0 + k);
    end
    $display("test manual done");
    for (int i = 0; i < 5; i++)
    begin
      wr(fwr_pkg::REG_CMD, 32'h1);
      waitRec();
      rd(fwr_pkg::REG_STATUS);
      chk("full", {28'h0, d[7:4]}, (i < 4) ? 5 + i : 8);
    end
    wr(fwr_pkg::REG_RECSEL, 32'h0);
    rd(fwr_pkg::REG_RECINFO);
    chk("oldest", {31'h0, d[28]}, 32'h1);
    $display("test store done");
    wr(fwr_pkg::REG_CTRL, 32'h20);
    fwr_prot_model_inst.drive(4'h2, 30 * SC);
    waitRec();
    wr(fwr_pkg::REG_RECSEL, 32'h7);
    rd(fwr_pkg::REG_RECINFO);
    chk("infLen", {31'h0, d[12:0] > 13'h7d && d[12:0] < 13'h87}, 32'h1);
    wr(fwr_pkg::REG_CMD, 32'h1);
    waitRec();
    rc("cap", fwr_pkg::REG_RECINFO, 32'h0032_012c);
    chk("xferEnd", nXfer, 32'h2);
    $display("test infinite done");
    give_verdict();
  end
endmodule : fwr_recorder_tb
bind fwr_recorder fwr_recorder_props #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) fwr_recorder_props_inst (.clk(clk),
  .rst(rst), .regRd(regRd), .regRdData(regRdData), .recordActive(recordActive),
  .recordStartEvent(recordStartEvent), .xferRequest(xferRequest));
